// ==== verilog/adcrt_pkg.sv ====
// Package with register map, field layout and trigger codes of the converter result/trigger block.
`default_nettype none
package adcrt_pkg;
  // ----------------------------------------------------------------
  // Register offsets (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_CONTROL_0 = 12'h000;
  localparam logic [11:0] OFF_CONTROL_1 = 12'h004;
  localparam logic [11:0] OFF_TRIGGER = 12'h008;
  localparam logic [11:0] OFF_RESULT_HIGH = 12'h00c;
  localparam logic [11:0] OFF_RESULT_LOW = 12'h010;
  localparam logic [11:0] OFF_ENGINE_RESULT = 12'h014;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL0_ON_BIT = 0;
  localparam int CTL0_GO_BIT = 1;
  localparam int CTL1_JUSTIFY_BIT = 7;
  localparam int RES_W = 10;
  localparam int TRIG_W = 5;
  localparam int TRIG_N = 18;
  localparam logic [7:0] CTL0_WMASK = 8'hff;
  localparam logic [7:0] CTL1_WMASK = 8'hf7;
  localparam logic [7:0] TRIG_WMASK = 8'h1f;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [TRIG_W-1:0] TRIG_NONE = 5'h00;
  // Conversion time in pclk cycles for the stand-in engine handshake.
  localparam logic [4:0] CONV_CYCLES = 5'h0b;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic start;
    logic [5:0] channel_select;
  } adcrt_conv_req_t;

  typedef struct packed {
    logic done;
    logic [RES_W-1:0] conversion_result;
  } adcrt_conv_rsp_t;

  typedef enum logic [0:0] {
    JUSTIFY_LEFT,
    JUSTIFY_RIGHT
  } adcrt_justify_t;
endpackage : adcrt_pkg
`default_nettype wire

// ==== verilog/adcrt_trigger.sv ====
// Selects one auto-conversion trigger source and detects its rising edge.
`timescale 1ns/100ps
`default_nettype none
module adcrt_trigger (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Sources and selection
  input wire logic [adcrt_pkg::TRIG_N-1:0] trigger_sources,
  input wire logic [adcrt_pkg::TRIG_W-1:0] auto_trigger_select,
  // Event
  output logic trigger_event
);
  import adcrt_pkg::*;

  logic [TRIG_N-1:0] src_q;
  logic [TRIG_N-1:0] rise;
  logic sel_rise;

  // Each source is a peripheral interrupt flag; its setting instant is the event.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q <= '0;
    end else begin
      src_q <= trigger_sources;
    end
  end

  genvar g;
  generate
    for (g = 0; g < TRIG_N; g++) begin : g_edge
      assign rise[g] = trigger_sources[g] && !src_q[g];
    end
  endgenerate

  // Code zero and codes above 18 select nothing; code n picks source n-1.
  always_comb begin
    sel_rise = 1'b0;
    if (auto_trigger_select != TRIG_NONE && auto_trigger_select <= TRIG_W'(TRIG_N)) begin
      sel_rise = rise[auto_trigger_select - TRIG_W'(1)];
    end
  end

  assign trigger_event = sel_rise;
endmodule // adcrt_trigger
`default_nettype wire

// ==== verilog/adcrt_justify.sv ====
// Formats a 10-bit result into high and low result bytes by justification.
`timescale 1ns/100ps
`default_nettype none
module adcrt_justify (
  // Inputs
  input wire logic [adcrt_pkg::RES_W-1:0] conversion_result,
  input wire logic result_justify_select,
  // Formatted bytes
  output logic [7:0] high_byte,
  output logic [7:0] low_byte
);
  import adcrt_pkg::*;

  always_comb begin
    if (result_justify_select == JUSTIFY_RIGHT) begin
      high_byte = {6'h00, conversion_result[9:8]};
      low_byte = conversion_result[7:0];
    end else begin
      high_byte = conversion_result[9:2];
      low_byte = {conversion_result[1:0], 6'h00};
    end
  end
endmodule // adcrt_justify
`default_nettype wire

// ==== verilog/adcrt_regs.sv ====
// APB register block for converter control, auto-trigger select and result bytes.
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module adcrt_regs (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Auto-conversion trigger sources (peripheral interrupt flags)
  input wire logic [adcrt_pkg::TRIG_N-1:0] trigger_sources,
  // Conversion engine
  output adcrt_pkg::adcrt_conv_req_t conv_req,
  input wire adcrt_pkg::adcrt_conv_rsp_t conv_rsp,
  // Control levels
  output logic converter_on,
  output logic [2:0] conversion_clock_select,
  output logic negative_reference_select,
  output logic [1:0] positive_reference_select
);
  import adcrt_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] control_0_q;
  logic [7:0] control_1_q;
  logic [TRIG_W-1:0] trigger_q;
  logic [7:0] result_high_q;
  logic [7:0] result_low_q;
  logic [RES_W-1:0] last_result_q;
  logic busy_q;
  logic [31:0] prdata_q;
  logic trigger_event;
  logic [7:0] fmt_high;
  logic [7:0] fmt_low;
  logic wr_access;
  logic rd_access;
  logic addr_ok;

  function automatic logic decode_ok(input logic [11:0] a);
    decode_ok = (a == OFF_CONTROL_0) || (a == OFF_CONTROL_1) || (a == OFF_TRIGGER) ||
                (a == OFF_RESULT_HIGH) || (a == OFF_RESULT_LOW) || (a == OFF_ENGINE_RESULT);
  endfunction

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wmask);
    merge = (old & ~wmask) | (pwdata[7:0] & wmask);
  endfunction

  // ----------------------------------------------------------------
  // APB handshake
  // ----------------------------------------------------------------
  assign addr_ok = decode_ok(paddr);
  assign wr_access = psel && penable && pwrite && pstrb[0] && addr_ok;
  assign rd_access = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  adcrt_trigger u_trigger (
    .pclk(pclk),
    .presetn(presetn),
    .trigger_sources(trigger_sources),
    .auto_trigger_select(trigger_q),
    .trigger_event(trigger_event)
  );

  adcrt_justify u_justify (
    .conversion_result(conv_rsp.conversion_result),
    .result_justify_select(control_1_q[CTL1_JUSTIFY_BIT]),
    .high_byte(fmt_high),
    .low_byte(fmt_low)
  );

  // ----------------------------------------------------------------
  // Control register 0 with on bit and go/done flag
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_0_q <= CTL_RESET;
    end else begin
      logic [7:0] nxt;
      nxt = control_0_q;
      if (wr_access && paddr == OFF_CONTROL_0) begin
        nxt = merge(control_0_q, CTL0_WMASK);
      end
      // Completion clears go; a trigger in the same cycle starts the next one.
      if (conv_rsp.done && busy_q) begin
        nxt[CTL0_GO_BIT] = 1'b0;
      end
      if (trigger_event && control_0_q[CTL0_ON_BIT]) begin
        nxt[CTL0_GO_BIT] = 1'b1;
      end
      control_0_q <= nxt;
    end
  end

  // A start pulse issues whenever go and on are set and no conversion is busy.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
    end else if (conv_req.start) begin
      busy_q <= 1'b1;
    end else if (conv_rsp.done) begin
      busy_q <= 1'b0;
    end
  end

  assign conv_req.start = control_0_q[CTL0_GO_BIT] && control_0_q[CTL0_ON_BIT] && !busy_q;
  assign conv_req.channel_select = control_0_q[7:2];

  // ----------------------------------------------------------------
  // Control register 1 and trigger select
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_1_q <= CTL_RESET;
    end else if (wr_access && paddr == OFF_CONTROL_1) begin
      control_1_q <= merge(control_1_q, CTL1_WMASK);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trigger_q <= TRIG_NONE;
    end else if (wr_access && paddr == OFF_TRIGGER) begin
      trigger_q <= pwdata[TRIG_W-1:0];
    end
  end

  assign converter_on = control_0_q[CTL0_ON_BIT];
  assign conversion_clock_select = control_1_q[6:4];
  assign negative_reference_select = control_1_q[2];
  assign positive_reference_select = control_1_q[1:0];

  // ----------------------------------------------------------------
  // Result bytes: no reset, so contents survive every reset but power-up
  // ----------------------------------------------------------------
  always_ff @(posedge pclk) begin
    if (conv_rsp.done && busy_q) begin
      result_high_q <= fmt_high;
      result_low_q <= fmt_low;
      last_result_q <= conv_rsp.conversion_result;
    end else begin
      if (wr_access && paddr == OFF_RESULT_HIGH) begin
        result_high_q <= pwdata[7:0];
      end
      if (wr_access && paddr == OFF_RESULT_LOW) begin
        result_low_q <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data, captured in the setup phase
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_access) begin
      case (paddr)
        OFF_CONTROL_0: prdata_q <= {24'h00_0000, control_0_q};
        OFF_CONTROL_1: prdata_q <= {24'h00_0000, control_1_q};
        OFF_TRIGGER: prdata_q <= {27'h000_0000, trigger_q};
        OFF_RESULT_HIGH: prdata_q <= {24'h00_0000, result_high_q};
        OFF_RESULT_LOW: prdata_q <= {24'h00_0000, result_low_q};
        OFF_ENGINE_RESULT: prdata_q <= {22'h00_0000, last_result_q};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata = prdata_q;
endmodule // adcrt_regs
`default_nettype wire

// ==== dv/adcrt_regs_props.sv ====
// Checker for the converter result and trigger register block.
`timescale 1ns/100ps
`default_nettype none
module adcrt_regs_props (
  // Clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Trigger and engine
  input wire logic [adcrt_pkg::TRIG_N-1:0] trigger_sources,
  input wire adcrt_pkg::adcrt_conv_req_t conv_req,
  input wire adcrt_pkg::adcrt_conv_rsp_t conv_rsp,
  input wire logic converter_on
);
  import adcrt_pkg::*;
  logic [TRIG_N-1:0] src_q;
  logic [4:0] sel_q;
  logic [2:0] quiet_q;
  logic busy_q, rise, wr;
  assign wr = psel && penable && pwrite && pstrb[0];
  assign rise = sel_q != 5'h00 && sel_q <= 5'h12 && trigger_sources[sel_q - 5'h01] && !src_q[sel_q - 5'h01];
  // ----
  // Shadow of the trigger selection and of the engine's busy time.
  // ----
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q <= '0;
      sel_q <= 5'h00;
      busy_q <= 1'b0;
      quiet_q <= 3'h7;
    end else begin
      src_q <= trigger_sources;
      if (wr && paddr == OFF_TRIGGER) begin
        sel_q <= pwdata[4:0];
      end
      busy_q <= conv_req.start || (busy_q && !conv_rsp.done);
      quiet_q <= (rise || (wr && paddr == OFF_CONTROL_0)) ? 3'h0 : quiet_q + {2'h0, quiet_q != 3'h7};
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence rd_acc;
    psel && penable && !pwrite;
  endsequence
  sequence start_soon;
    ##[1:3] conv_req.start;
  endsequence
  trig_start_a: assert property (rise && converter_on && !busy_q && !conv_req.start |-> start_soon)
    else $error("selected trigger edge started no conversion");
  start_cause_a: assert property ($rose(conv_req.start) |-> quiet_q < 3'h4)
    else $error("conversion started without a cause");
  start_on_a: assert property (conv_req.start |-> converter_on)
    else $error("conversion started with converter off");
  busy_hold_a: assert property (busy_q |-> !conv_req.start)
    else $error("conversion started while busy");
  upper_zero_a: assert property (rd_acc ##0 paddr != OFF_ENGINE_RESULT |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  trig_gap_a: assert property (rd_acc ##0 paddr == OFF_TRIGGER |-> prdata[7:5] == 3'h0)
    else $error("trigger select top bits not zero");
  ctl1_gap_a: assert property (rd_acc ##0 paddr == OFF_CONTROL_1 |-> !prdata[3])
    else $error("control 1 bit 3 not zero");
  bad_addr_a: assert property (psel && penable && (paddr[1:0] != 2'h0 || paddr > OFF_ENGINE_RESULT)
    |-> pslverr && (pwrite || prdata == 32'h0000_0000))
    else $error("unmapped access not refused");
endmodule // adcrt_regs_props
bind adcrt_regs adcrt_regs_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pslverr(pslverr), .trigger_sources(trigger_sources),
  .conv_req(conv_req), .conv_rsp(conv_rsp), .converter_on(converter_on)
);
`default_nettype wire

// ==== dv/adc_result_trigger_regs_tb.sv ====
// Self-checking bench for the converter result and trigger register block.
`timescale 1ns/100ps
`default_nettype none
module adc_result_trigger_regs_tb;
  import adcrt_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, err, converter_on, nref;
  logic [2:0] ccs;
  logic [1:0] pref;
  logic [9:0] res;
  logic [TRIG_N-1:0] trigger_sources = '0;
  adcrt_conv_req_t conv_req;
  adcrt_conv_rsp_t conv_rsp = '0;
  int error_cnt = 0, checks_done = 0, seed = 27, starts = 0;
  adcrt_regs DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trigger_sources(trigger_sources), .conv_req(conv_req), .conv_rsp(conv_rsp), .converter_on(converter_on),
    .conversion_clock_select(ccs), .negative_reference_select(nref), .positive_reference_select(pref)
  );
  always #20 pclk = ~pclk;
  always @(posedge pclk) if (conv_req.start === 1'b1) starts <= starts + 1;
  function automatic logic [15:0] place(input logic [9:0] r, input logic j);
    return j ? {6'h00, r} : {r, 6'h00};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int w;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    w = 0;
    do begin
      @(posedge pclk);
      w++;
    end while (pready !== 1'b1 && w < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // ----
  // One conversion started by a trigger edge, then both result bytes read back.
  // ----
  task automatic convert(input logic [4:0] code, input logic j);
    int n;
    int w;
    logic [15:0] e;
    res = 10'($random(seed));
    e = place(res, j);
    apb(1'b1, OFF_CONTROL_1, {24'h0, j, 7'h00});
    apb(1'b1, OFF_TRIGGER, {27'h000_0000, code});
    apb(1'b1, OFF_CONTROL_0, 32'h0000_0001);
    n = starts;
    trigger_sources <= TRIG_N'($random(seed)) & ~(18'h0_0001 << (code - 5'h01));
    repeat (4) @(posedge pclk);
    check(starts - n, 0);
    trigger_sources[code - 5'h01] <= 1'b1;
    w = 0;
    while (starts == n && w < 10) begin
      @(posedge pclk);
      w++;
    end
    conv_rsp <= {1'b1, res};
    @(posedge pclk);
    conv_rsp <= '0;
    repeat (4) @(posedge pclk);
    trigger_sources <= '0;
    repeat (4) @(posedge pclk);
    check(starts - n, 1);
    apb(1'b0, OFF_CONTROL_0, 0);
    check(rd, 32'h0000_0001);
    apb(1'b0, OFF_RESULT_HIGH, 0);
    check(rd & (j ? 32'h0000_0003 : 32'h0000_00ff), {24'h0, e[15:8]});
    apb(1'b0, OFF_RESULT_LOW, 0);
    check(rd & (j ? 32'h0000_00ff : 32'h0000_00c0), {24'h0, e[7:0]});
    apb(1'b0, OFF_ENGINE_RESULT, 0);
    check(rd, {22'h0, res});
    check({30'h0, err, pready}, 32'h0000_0001);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #2_000_000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFF_CONTROL_0, 0);
    check(rd, 32'h0000_0000);
    apb(1'b1, OFF_CONTROL_1, 32'hffff_ffff);
    apb(1'b0, OFF_CONTROL_1, 0);
    check(rd, 32'h0000_00f7);
    check({26'h0, ccs, nref, pref}, 32'h0000_003f);
    apb(1'b1, OFF_TRIGGER, 32'hffff_ffff);
    apb(1'b0, OFF_TRIGGER, 0);
    check(rd, 32'h0000_001f);
    apb(1'b0, 12'h0f0, 0);
    check({err, rd[30:0]}, 32'h8000_0000);
    res = 10'($random(seed));
    apb(1'b1, OFF_RESULT_HIGH, {22'h0, res});
    apb(1'b0, OFF_RESULT_HIGH, 0);
    check(rd, {24'h0, res[7:0]});
    apb(1'b1, OFF_CONTROL_0, 32'h0000_00fc);
    check({25'h0, converter_on, conv_req.channel_select}, 32'h0000_003f);
    check(starts, 0);
    $display("register map test done");
    apb(1'b1, OFF_TRIGGER, 0);
    apb(1'b1, OFF_CONTROL_0, 32'h0000_0001);
    trigger_sources <= '1;
    repeat (6) @(posedge pclk);
    check(starts, 0);
    trigger_sources <= '0;
    for (int i = 0; i < 8; i++) begin
      convert(i == 0 ? 5'h01 : i == 1 ? 5'h12 : 5'h01 + 5'($unsigned($random(seed)) % TRIG_N), i[0]);
    end
    $display("conversion tests done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFF_RESULT_LOW, 0);
    check(rd, {24'h0, res[7:0]});
    apb(1'b0, OFF_CONTROL_1, 0);
    check(rd, 32'h0000_0000);
    check({31'h0, converter_on}, 32'h0000_0000);
    $display("reset retention test done");
    report_and_stop();
  end
endmodule // adc_result_trigger_regs_tb
`default_nettype wire
